// File: hw/rms_map.svh
`ifndef RMS_MAP_SVH
`define RMS_MAP_SVH

// Register byte offsets
`define RMS_ADDR_W          12
`define RMS_OFF_COND        12'h000
`define RMS_OFF_CYCLE       12'h004
`define RMS_OFF_STATUS      12'h008
`define RMS_OFF_CLEAR       12'h00c

// Reset values
`define RMS_COND_RST        8'h00
`define RMS_CYCLE_RST       16'h03e8

// Minimum communication cycle, 0.250 ms, held in microseconds
`define RMS_MIN_CYCLE_US    16'h00fa

// Condition setting nibble codes
`define RMS_IO_OFF          4'h0
`define RMS_IO_EDGE         4'h1
`define RMS_IO_NEAR         4'h2
`define RMS_IO_POWER        4'h3
`define RMS_COMM_OFF        4'h0
`define RMS_COMM_ON         4'h1

// Alarm codes
`define RMS_ALM_MAIN        8'h57
`define RMS_SUB_IO          4'h1
`define RMS_SUB_COMM        4'h2
`define RMS_SUB_FAULT       4'h3

// Status field positions
`define RMS_ST_IO           0
`define RMS_ST_COMM         1
`define RMS_ST_FAULT        2
`define RMS_ST_FSM_LO       4
`define RMS_ST_FSM_HI       7
`define RMS_ST_ARMED        8
`define RMS_ST_SRC          9
`define RMS_ST_MAIN_LO      16
`define RMS_ST_MAIN_HI      23
`define RMS_ST_SUB_LO       24
`define RMS_ST_SUB_HI       27

`endif

// File: hw/rms_pkg.sv
package rms_pkg;

   typedef enum logic [3:0] {
      RMS_IDLE  = 4'h1,
      RMS_STOP  = 4'h2,
      RMS_MOVE  = 4'h4,
      RMS_HOLD  = 4'h8
   } rms_fsm_type;

   typedef struct packed {
      logic        reqIn;
      logic        nearIn;
      logic        powerOffIn;
      logic        commAlmIn;
   } rms_samp_type;

   typedef struct packed {
      rms_fsm_type  fsm;
      rms_samp_type prev;
      logic         armed;
      logic         srcComm;
      logic [7:0]   cond;
      logic [15:0]  cycleUs;
      logic         almIo;
      logic         almComm;
      logic         almFault;
      logic         maxDecel;
      logic         retractMove;
      logic         haltCmd;
      logic         brakeRel;
      logic         energize;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } rms_state_type;

endpackage

// File: hw/rms_sequencer.sv
// Contract
// - Retract on I/O or communication trigger
// - Low nibble 1: request rising edge triggers
// - Low nibble 2: request rises, near-origin on
// - Low nibble 2: near-origin rises while armed
// - Low nibble 3: main power loss triggers
// - High nibble 1: communication alarm triggers
// - I/O retract done raises alarm 87.1
// - Comm retract done raises alarm 87.2
// - Invalid condition setting raises fault alarm
// - Enabled with too short cycle faults
// - Travel inhibit during retract suspends, faults
// - Trigger under travel inhibit is refused
// - Trigger during non-host motion faults
// - Other alarm during retract suspends, faults
// - Trigger with servo off faults
// - Moving motor: max-decel stop, then retract
// - Command decel: max-decel stop, then retract
// - Protective decel: halt, no retract, fault
// - After completion hold energy until brake
// - Stopped motor: retract directly
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rms_map.svh"

module rms_sequencer
   import rms_pkg::*;
(
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`RMS_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   retractRequestInput,
   input  wire logic                   nearOriginInput,
   input  wire logic                   mainPowerOff,
   input  wire logic                   processDataWatchdogAlarm,
   input  wire logic                   syncSignalAlarm,
   input  wire logic                   linkLossAlarm,
   input  wire logic                   positiveTravelInhibit,
   input  wire logic                   negativeTravelInhibit,
   input  wire logic                   otherAlarm,
   input  wire logic                   servoOn,
   input  wire logic                   hostMotion,
   input  wire logic                   motorMoving,
   input  wire logic                   commandDecel,
   input  wire logic                   protectiveDecel,
   input  wire logic                   motorStopped,
   input  wire logic                   retractMoveDone,
   input  wire logic                   brakeEngaged,
   output logic                        retractDoneIoAlarm,
   output logic                        retractDoneCommAlarm,
   output logic                        retractFaultAlarm,
   output logic                        maxDecelStop,
   output logic                        retractMove,
   output logic                        haltPositionCommand,
   output logic                        brakeReleaseOutput,
   output logic                        keepEnergized
);

   rms_state_type s_r;
   rms_state_type s_nxt;

   rms_samp_type  samp;
   logic          reqRise;
   logic          nearRise;
   logic          powerRise;
   logic          commRise;
   logic          trigIo;
   logic          trigComm;
   logic          trig;
   logic          inhibit;
   logic          condBad;
   logic          cycleBad;
   logic          busy;
   logic          setup;
   logic          wrDone;
   logic [3:0]    riseVec;
   genvar         gi;
   logic [3:0]    ioSel;
   logic [3:0]    commSel;
   logic [31:0]   status;

   function automatic logic rises(input logic prevV, input logic curV);
      rises = ~prevV & curV;
   endfunction

   function automatic logic mapped(input logic [`RMS_ADDR_W-1:0] a);
      mapped = (a == `RMS_OFF_COND) || (a == `RMS_OFF_CYCLE) ||
               (a == `RMS_OFF_STATUS) || (a == `RMS_OFF_CLEAR);
   endfunction

   assign samp.reqIn      = retractRequestInput;
   assign samp.nearIn     = nearOriginInput;
   assign samp.powerOffIn = mainPowerOff;
   assign samp.commAlmIn  = processDataWatchdogAlarm | syncSignalAlarm |
                            linkLossAlarm;

   assign ioSel   = s_r.cond[3:0];
   assign commSel = s_r.cond[7:4];
   assign inhibit = positiveTravelInhibit | negativeTravelInhibit;
   assign busy    = (s_r.fsm == RMS_STOP) || (s_r.fsm == RMS_MOVE);

   // One edge detector per sampled input: previous sample against current
   generate
      for (gi = 0; gi < 4; gi++) begin : g_rise
         assign riseVec[gi] = rises(s_r.prev[gi], samp[gi]);
      end
   endgenerate

   assign reqRise   = riseVec[3];
   assign nearRise  = riseVec[2];
   assign powerRise = riseVec[1];
   assign commRise  = riseVec[0];

   always_comb begin
      s_nxt      = s_r;
      s_nxt.prev = samp;

      condBad = ~((ioSel <= `RMS_IO_POWER) &&
                  (commSel <= `RMS_COMM_ON));
      cycleBad = (s_r.cond != `RMS_COND_RST) &&
                 (s_r.cycleUs < `RMS_MIN_CYCLE_US);

      trigIo = 1'b0;
      case (ioSel)
         `RMS_IO_EDGE: begin
            trigIo = reqRise;
         end
         `RMS_IO_NEAR: begin
            trigIo = (reqRise & samp.nearIn) |
                     (s_r.armed & nearRise);
         end
         `RMS_IO_POWER: begin
            trigIo = powerRise;
         end
         default: begin
            trigIo = 1'b0;
         end
      endcase
      trigComm = (commSel == `RMS_COMM_ON) & commRise;
      trig     = (trigIo | trigComm) & ~condBad & ~cycleBad;

      // Near-origin arm window after a request edge
      if (ioSel == `RMS_IO_NEAR && reqRise && !samp.nearIn) begin
         s_nxt.armed = 1'b1;
      end
      if (!samp.reqIn || s_r.almIo || s_r.almComm ||
          s_r.almFault || trigIo) begin
         s_nxt.armed = 1'b0;
      end

      // Software clears alarms by writing ones
      setup  = psel & ~penable;
      wrDone = psel & penable & s_r.pready & pwrite;
      if (wrDone && paddr == `RMS_OFF_CLEAR) begin
         if (pwdata[`RMS_ST_IO]) begin
            s_nxt.almIo = 1'b0;
         end
         if (pwdata[`RMS_ST_COMM]) begin
            s_nxt.almComm = 1'b0;
         end
         if (pwdata[`RMS_ST_FAULT]) begin
            s_nxt.almFault = 1'b0;
            s_nxt.haltCmd  = 1'b0;
         end
      end
      if (wrDone && paddr == `RMS_OFF_COND) begin
         s_nxt.cond = pwdata[7:0];
      end
      if (wrDone && paddr == `RMS_OFF_CYCLE) begin
         s_nxt.cycleUs = pwdata[15:0];
      end

      if (condBad || cycleBad) begin
         s_nxt.almFault = 1'b1;
      end
      if ((trigIo | trigComm) && (condBad || cycleBad)) begin
         s_nxt.haltCmd = 1'b1;
      end

      case (s_r.fsm)
         RMS_IDLE: begin
            if (trig) begin
               s_nxt.srcComm = ~trigIo & trigComm;
               if (inhibit || !hostMotion || !servoOn ||
                   protectiveDecel) begin
                  s_nxt.almFault = 1'b1;
                  s_nxt.haltCmd  = 1'b1;
               end else if (motorMoving || commandDecel) begin
                  s_nxt.fsm      = RMS_STOP;
                  s_nxt.maxDecel = 1'b1;
               end else begin
                  s_nxt.fsm         = RMS_MOVE;
                  s_nxt.retractMove = 1'b1;
               end
            end
         end
         RMS_STOP: begin
            if (motorStopped) begin
               s_nxt.fsm         = RMS_MOVE;
               s_nxt.maxDecel    = 1'b0;
               s_nxt.retractMove = 1'b1;
            end
         end
         RMS_MOVE: begin
            // Completion loses to a suspension seen in the same cycle
            if (retractMoveDone && !inhibit && !otherAlarm) begin
               s_nxt.fsm         = RMS_HOLD;
               s_nxt.retractMove = 1'b0;
               s_nxt.brakeRel    = 1'b1;
               s_nxt.energize    = 1'b1;
               if (s_r.srcComm) begin
                  s_nxt.almComm = 1'b1;
               end else begin
                  s_nxt.almIo = 1'b1;
               end
            end
         end
         RMS_HOLD: begin
            if (brakeEngaged) begin
               s_nxt.fsm      = RMS_IDLE;
               s_nxt.energize = 1'b0;
            end
         end
         default: begin
            s_nxt.fsm = RMS_IDLE;
         end
      endcase

      // Suspension overrides any progress made this cycle
      if (busy && (inhibit || otherAlarm)) begin
         s_nxt.fsm         = RMS_IDLE;
         s_nxt.maxDecel    = 1'b0;
         s_nxt.retractMove = 1'b0;
         s_nxt.almFault    = 1'b1;
         s_nxt.haltCmd     = 1'b1;
      end

      // Brake release follows the completion alarm once back in idle
      if (s_r.fsm == RMS_IDLE && !s_nxt.almIo && !s_nxt.almComm) begin
         s_nxt.brakeRel = 1'b0;
      end

      // APB: data captured in setup, answer in first access cycle
      status = 32'h0000_0000;
      status[`RMS_ST_IO]                     = s_r.almIo;
      status[`RMS_ST_COMM]                   = s_r.almComm;
      status[`RMS_ST_FAULT]                  = s_r.almFault;
      status[`RMS_ST_FSM_HI:`RMS_ST_FSM_LO]  = s_r.fsm;
      status[`RMS_ST_ARMED]                  = s_r.armed;
      status[`RMS_ST_SRC]                    = s_r.srcComm;
      if (s_r.almIo || s_r.almComm || s_r.almFault) begin
         status[`RMS_ST_MAIN_HI:`RMS_ST_MAIN_LO] = `RMS_ALM_MAIN;
      end
      if (s_r.almFault) begin
         status[`RMS_ST_SUB_HI:`RMS_ST_SUB_LO] = `RMS_SUB_FAULT;
      end else if (s_r.almComm) begin
         status[`RMS_ST_SUB_HI:`RMS_ST_SUB_LO] = `RMS_SUB_COMM;
      end else if (s_r.almIo) begin
         status[`RMS_ST_SUB_HI:`RMS_ST_SUB_LO] = `RMS_SUB_IO;
      end

      s_nxt.pready = setup;
      if (setup) begin
         s_nxt.pslverr = ~mapped(paddr) |
                         (pwrite & (paddr == `RMS_OFF_STATUS));
         s_nxt.prdata  = 32'h0000_0000;
         if (!pwrite) begin
            case (paddr)
               `RMS_OFF_COND: begin
                  s_nxt.prdata = {24'h00_0000, s_r.cond};
               end
               `RMS_OFF_CYCLE: begin
                  s_nxt.prdata = {16'h0000, s_r.cycleUs};
               end
               `RMS_OFF_STATUS: begin
                  s_nxt.prdata = status;
               end
               default: begin
                  s_nxt.prdata = 32'h0000_0000;
               end
            endcase
         end
      end else if (!(psel && penable && !s_r.pready)) begin
         s_nxt.pslverr = 1'b0;
         s_nxt.prdata  = 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r             <= '0;
         s_r.fsm         <= RMS_IDLE;
         s_r.cond        <= `RMS_COND_RST;
         s_r.cycleUs     <= `RMS_CYCLE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata               = s_r.prdata;
   assign pready               = s_r.pready;
   assign pslverr              = s_r.pslverr;
   assign retractDoneIoAlarm   = s_r.almIo;
   assign retractDoneCommAlarm = s_r.almComm;
   assign retractFaultAlarm    = s_r.almFault;
   assign maxDecelStop         = s_r.maxDecel;
   assign retractMove          = s_r.retractMove;
   assign haltPositionCommand  = s_r.haltCmd;
   assign brakeReleaseOutput   = s_r.brakeRel;
   assign keepEnergized        = s_r.energize;

endmodule

`default_nettype wire

// File: tb/rms_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rms_chk (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic positiveTravelInhibit,
   input wire logic negativeTravelInhibit,
   input wire logic otherAlarm,
   input wire logic servoOn,
   input wire logic hostMotion,
   input wire logic protectiveDecel,
   input wire logic motorStopped,
   input wire logic retractMoveDone,
   input wire logic brakeEngaged,
   input wire logic retractDoneIoAlarm,
   input wire logic retractDoneCommAlarm,
   input wire logic retractFaultAlarm,
   input wire logic maxDecelStop,
   input wire logic retractMove,
   input wire logic keepEnergized
);
   wire inh = positiveTravelInhibit | negativeTravelInhibit;
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence halted;
      maxDecelStop && motorStopped && !inh && !otherAlarm;
   endsequence
   sequence moveDone;
      retractMove && retractMoveDone && !inh && !otherAlarm;
   endsequence
   sequence busy;
      (retractMove || maxDecelStop) && !retractMoveDone;
   endsequence
   chk_stop_move: assert property (
      halted |=> retractMove && !maxDecelStop) else $error("no move");
   chk_done_alarm: assert property (
      moveDone |=> !retractMove && keepEnergized
      && (retractDoneIoAlarm || retractDoneCommAlarm)) else $error("no done");
   chk_energy_hold: assert property (
      keepEnergized && !brakeEngaged |=> keepEnergized) else $error("early");
   chk_energy_drop: assert property (
      keepEnergized && brakeEngaged |=> !keepEnergized) else $error("late");
   chk_inhibit_abort: assert property (
      busy ##0 inh |=> !retractMove && !maxDecelStop && retractFaultAlarm)
      else $error("inhibit kept move");
   chk_alarm_abort: assert property (
      busy ##0 otherAlarm |=> !retractMove && retractFaultAlarm)
      else $error("alarm kept move");
   chk_direct_move: assert property (
      $rose(retractMove) && !$past(maxDecelStop) |-> $past(motorStopped))
      else $error("move while moving");
   chk_refuse_move: assert property (
      ($rose(retractMove) && !$past(maxDecelStop)) || $rose(maxDecelStop)
      |-> $past(servoOn && hostMotion && !protectiveDecel && !inh))
      else $error("blocked start");
endmodule
bind rms_sequencer rms_chk chk (.*);
`default_nettype wire

// File: tb/rms_partner.sv
`timescale 1ns/1ps
`default_nettype none
module rms_partner #(
   parameter int DLY = 8
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic startMove,
   input  wire logic maxDecelStop,
   input  wire logic retractMove,
   input  wire logic brakeReleaseOutput,
   output logic      motorMoving,
   output logic      motorStopped,
   output logic      retractMoveDone,
   output logic      brakeEngaged
);
   logic [7:0] decelCnt, moveCnt;
   assign motorStopped = !motorMoving;
   assign retractMoveDone = moveCnt == 8'(DLY);
   // Motor halt takes DLY+1 cycles, retract travel takes DLY cycles
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         {decelCnt, moveCnt, motorMoving, brakeEngaged} <= '0;
      end else begin
         decelCnt <= maxDecelStop ? decelCnt + 8'h01 : 8'h00;
         moveCnt <= retractMove ? moveCnt + 8'h01 : 8'h00;
         brakeEngaged <= brakeReleaseOutput;
         if (startMove) begin
            motorMoving <= 1'b1;
         end else if (decelCnt == 8'(DLY)) begin
            motorMoving <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/rms_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rms_map.svh"
module rms_sequencer_tb;
   typedef struct packed {
      logic [7:0]  cond;
      logic [15:0] cyc;
      logic [2:0]  a;
      logic [2:0]  b;
      logic        mv;
      logic [4:0]  env;
      logic [2:0]  exp;
   } rms_row_type;
   logic        core_clk, rst_n, psel, penable, pwrite, startMove, e;
   logic        negativeTravelInhibit, otherAlarm;
   logic [11:0] paddr;
   logic [31:0] pwdata, q;
   logic [5:0]  ioIn;
   logic [4:0]  env;
   wire  [31:0] prdata;
   wire         pready, pslverr, retractDoneIoAlarm, retractDoneCommAlarm;
   wire         retractFaultAlarm, maxDecelStop, retractMove, keepEnergized;
   wire         haltPositionCommand, brakeReleaseOutput, motorMoving;
   wire         motorStopped, retractMoveDone, brakeEngaged, commandDecel;
   wire         retractRequestInput, nearOriginInput, mainPowerOff;
   wire         processDataWatchdogAlarm, syncSignalAlarm, linkLossAlarm;
   wire         protectiveDecel, servoOn, hostMotion, positiveTravelInhibit;
   int          fails, cmp_count, i;
   rms_row_type rows [15];
   assign {linkLossAlarm, syncSignalAlarm, processDataWatchdogAlarm,
           mainPowerOff, nearOriginInput, retractRequestInput} = ioIn;
   // Env bits: protective decel, servo off, test run, inhibit, cmd decel
   assign {protectiveDecel, servoOn, hostMotion, positiveTravelInhibit,
           commandDecel} = env ^ 5'h0c;
   rms_sequencer dut (.*);
   rms_partner #(.DLY(8)) partner (.*);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task finish_test;
      if (fails == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task hang;
      fails++;
      finish_test;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: %h vs %h", $time, seen, want);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (n == 50) hang;
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task waitSig(input logic mv);
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge core_clk);
         if (mv ? retractMove : retractFaultAlarm || !keepEnergized
             && (retractDoneIoAlarm || retractDoneCommAlarm)) break;
      end
      if (n == 300) hang;
      repeat (2) @(posedge core_clk);
   endtask
   task arm(input logic [7:0] c, input logic [15:0] cy);
      {ioIn, env, negativeTravelInhibit, otherAlarm} <= '0;
      apb(1'b1, `RMS_OFF_COND, 32'h0);
      apb(1'b1, `RMS_OFF_CLEAR, 32'h7);
      apb(1'b1, `RMS_OFF_CYCLE, {16'h0, cy});
      apb(1'b1, `RMS_OFF_COND, {24'h0, c});
   endtask
   task runRow(input rms_row_type r);
      logic [3:0] sub;
      sub = r.exp[2] ? 4'h3 : r.exp[1] ? 4'h2 : 4'h1;
      arm(r.cond, r.cyc);
      env <= r.env;
      startMove <= r.mv;
      @(posedge core_clk);
      startMove <= 1'b0;
      ioIn[r.a] <= 1'b1;
      repeat (2) @(posedge core_clk);
      if (r.b < 3'h6) ioIn[r.b] <= 1'b1;
      waitSig(1'b0);
      apb(1'b0, `RMS_OFF_STATUS, 32'h0);
      check(q & 32'h0fff0007, {4'h0, sub, 8'h57, 13'h0, r.exp});
      check({31'h0, haltPositionCommand}, {31'h0, r.exp[2]});
      check({31'h0, brakeReleaseOutput}, {31'h0, |r.exp[1:0]});
   endtask
   initial begin
      {rst_n, psel, penable, pwrite, startMove} = '0;
      {paddr, pwdata, ioIn, env, negativeTravelInhibit, otherAlarm} = '0;
      {fails, cmp_count} = '0;
      rows = '{
         '{8'h01, 16'h00fa, 3'h0, 3'h7, 1'h0, 5'h00, 3'h1},
         '{8'h01, 16'h03e8, 3'h0, 3'h7, 1'h1, 5'h00, 3'h1},
         '{8'h01, 16'h03e8, 3'h0, 3'h7, 1'h1, 5'h01, 3'h1},
         '{8'h02, 16'h03e8, 3'h1, 3'h0, 1'h0, 5'h00, 3'h1},
         '{8'h02, 16'h03e8, 3'h0, 3'h1, 1'h0, 5'h00, 3'h1},
         '{8'h03, 16'h03e8, 3'h2, 3'h7, 1'h0, 5'h00, 3'h1},
         '{8'h10, 16'h03e8, 3'h3, 3'h7, 1'h0, 5'h00, 3'h2},
         '{8'h10, 16'h03e8, 3'h4, 3'h7, 1'h0, 5'h00, 3'h2},
         '{8'h10, 16'h03e8, 3'h5, 3'h7, 1'h1, 5'h00, 3'h2},
         '{8'h21, 16'h03e8, 3'h0, 3'h7, 1'h0, 5'h00, 3'h4},
         '{8'h01, 16'h00f9, 3'h0, 3'h7, 1'h0, 5'h00, 3'h4},
         '{8'h01, 16'h03e8, 3'h0, 3'h7, 1'h0, 5'h02, 3'h4},
         '{8'h01, 16'h03e8, 3'h0, 3'h7, 1'h0, 5'h04, 3'h4},
         '{8'h01, 16'h03e8, 3'h0, 3'h7, 1'h0, 5'h08, 3'h4},
         '{8'h01, 16'h03e8, 3'h0, 3'h7, 1'h0, 5'h10, 3'h4}};
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 15; i++) runRow(rows[i]);
      for (i = 0; i < 2; i++) begin
         arm(8'h01, 16'h03e8);
         ioIn <= 6'h01;
         waitSig(1'b1);
         negativeTravelInhibit <= i == 0;
         otherAlarm <= i == 1;
         waitSig(1'b0);
         check({retractFaultAlarm, retractMove, retractDoneIoAlarm}, 32'h4);
      end
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, `RMS_OFF_COND, 32'h0);
      check(q, 32'h0);
      apb(1'b0, `RMS_OFF_CYCLE, 32'h0);
      check(q, 32'h3e8);
      apb(1'b1, `RMS_OFF_STATUS, 32'hffff);
      check({31'h0, e}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      check(q, 32'h0);
      check({31'h0, e}, 32'h1);
      apb(1'b0, `RMS_OFF_STATUS, 32'h0);
      check(q, 32'h10);
      apb(1'b1, `RMS_OFF_COND, 32'h04);
      apb(1'b0, `RMS_OFF_STATUS, 32'h0);
      check(q, 32'h0357_0014);
      finish_test;
   end
endmodule
`default_nettype wire
